// ---- rtl/i2c_paged_pkg.sv ----
package i2c_paged_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          REG_W            = 8;
    localparam int          OFS_W            = 7;
    localparam int          PAGE_LOCS        = 128;
    localparam logic [6:0]  PAGE_SELECT_OFS  = 7'h00;
    localparam logic [6:0]  SOFT_RESET_OFS   = 7'h01;
    localparam logic [6:0]  SLEEP_CFG_OFS    = 7'h02;
    localparam int          SOFT_RESET_BIT   = 0;
    localparam int          BCAST_EN_BIT     = 2;
    localparam logic [7:0]  PAGE_SELECT_RST  = 8'h00;
    localparam logic [7:0]  CONFIG_PAGE      = 8'h00;
    localparam logic [7:0]  COEF_PAGE_FIRST  = 8'h02;
    localparam logic [7:0]  COEF_PAGE_LAST   = 8'h04;
    localparam int          STORED_PAGES     = 4;
    localparam int          MEM_AW           = 9;

    // ------------------------------------------------------------------
    // Link
    // ------------------------------------------------------------------
    localparam logic [6:0]  TARGET_ADDR      = 7'h4e;
    localparam logic [6:0]  BCAST_ADDR       = 7'h4c;
    localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
    localparam logic [3:0]  LAST_BIT_IDX     = 4'h7;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_REG,
        ST_REG_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } link_state_t;

endpackage

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_async,
    output var  logic o_sync
);

    logic meta_reg;

    // Idle level of an open-drain line is high
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_reg <= 1'b1;
            o_sync   <= 1'b1;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// ---- rtl/i2c_paged_target.sv ----
// Behaviour
// - Single-byte and multi-byte reads and writes work for every register.
// - Multi-byte read returns consecutive registers while the controller acknowledges.
// - First byte after address sets pointer; following bytes go to successive registers.
// - Target acknowledges matching address, register byte and every written data byte.
// - Read is register write, repeated start, address plus read bit, target data.
// - Each data byte of a multi-byte write is acknowledged; stop ends it.
// - Registers are 8 bits; pages hold 128 locations.
// - Active page is 0 after reset and after software reset.
// - Offset 0 of every page selects the active page.
// - Coefficient storage sits in pages 2, 3 and 4.
// - Target address 1001110, or 1001100 when broadcast enable is set.
// - Bytes travel MSB first, each followed by the receiver's acknowledge.
`timescale 1ns/1ps
`default_nettype none

module i2c_paged_target
    import i2c_paged_pkg::*;
(
    input  wire logic       I_CLK,
    input  wire logic       I_RST,
    input  wire logic       I_SCL,
    input  wire logic       I_SDA,
    output var  logic       O_SDA_OUT,
    output var  logic       O_SDA_OE,
    output var  logic [7:0] O_PAGE,
    output var  logic       O_BROADCAST_EN
);

    // ------------------------------------------------------------------
    // Pin synchronisers and bus conditions
    // ------------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic scl_d_reg;
    logic sda_d_reg;

    pin_sync u_scl_sync (
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_async (I_SCL),
        .o_sync  (scl_s)
    );

    pin_sync u_sda_sync (
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_async (I_SDA),
        .o_sync  (sda_s)
    );

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    wire scl_rise   = scl_s & ~scl_d_reg;
    wire scl_fall   = ~scl_s & scl_d_reg;
    // Start and stop only count while SCL stays high across both samples
    wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // ------------------------------------------------------------------
    // Register space
    // ------------------------------------------------------------------
    logic [REG_W-1:0] mem [0:STORED_PAGES*PAGE_LOCS-1];
    logic [7:0]       page_reg;
    logic             bcast_reg;
    logic [OFS_W-1:0] ptr_reg;

    wire       page_is_cfg  = (page_reg == CONFIG_PAGE);
    wire       page_is_coef = (page_reg >= COEF_PAGE_FIRST) && (page_reg <= COEF_PAGE_LAST);
    wire       page_stored  = page_is_cfg | page_is_coef;
    wire [1:0] page_idx     = page_is_cfg ? 2'h0 : 2'(page_reg - COEF_PAGE_FIRST + 8'h01);
    wire [MEM_AW-1:0] mem_addr = {page_idx, ptr_reg};

    // Reserved pages read as zero; offset 0 is the page selector on every page
    wire [7:0] mem_rdata = page_stored ? mem[mem_addr] : 8'h00;
    wire [7:0] reg_rdata = (ptr_reg == PAGE_SELECT_OFS) ? page_reg :
                           (page_is_cfg && ptr_reg == SOFT_RESET_OFS) ? 8'h00 :
                           mem_rdata;

    wire [6:0] own_addr  = bcast_reg ? BCAST_ADDR : TARGET_ADDR;

    // ------------------------------------------------------------------
    // Link state machine
    // ------------------------------------------------------------------
    link_state_t state_reg;
    logic [3:0]  cnt_reg;
    logic [7:0]  shift_reg;
    logic        rw_reg;
    logic        mack_reg;
    logic        oe_reg;

    wire byte_done  = (cnt_reg == BITS_PER_BYTE);
    wire [7:0] wbyte = shift_reg;
    wire do_write   = scl_fall && (state_reg == ST_WDATA) && byte_done;
    wire wr_page    = do_write && (ptr_reg == PAGE_SELECT_OFS);
    wire wr_swrst   = do_write && page_is_cfg && (ptr_reg == SOFT_RESET_OFS)
                      && wbyte[SOFT_RESET_BIT];
    wire wr_sleep   = do_write && page_is_cfg && (ptr_reg == SLEEP_CFG_OFS);
    wire wr_mem     = do_write && page_stored && (ptr_reg != PAGE_SELECT_OFS)
                      && !(page_is_cfg && ptr_reg == SOFT_RESET_OFS);

    always_ff @(posedge I_CLK) begin
        if (wr_mem) begin
            mem[mem_addr] <= wbyte;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST || wr_swrst) begin
            page_reg <= PAGE_SELECT_RST;
        end else if (wr_page) begin
            page_reg <= wbyte;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            bcast_reg <= 1'b0;
        end else if (wr_sleep) begin
            bcast_reg <= wbyte[BCAST_EN_BIT];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 4'h0;
            shift_reg <= 8'h00;
            rw_reg    <= 1'b0;
            mack_reg  <= 1'b0;
            oe_reg    <= 1'b0;
            ptr_reg   <= '0;
        end else if (start_cond) begin
            // A repeated start closes any sequential write in progress
            state_reg <= ST_ADDR;
            cnt_reg   <= 4'h0;
            oe_reg    <= 1'b0;
        end else if (stop_cond) begin
            state_reg <= ST_IDLE;
            oe_reg    <= 1'b0;
        end else if (scl_rise) begin
            case (state_reg)
                ST_ADDR, ST_REG, ST_WDATA: begin
                    shift_reg <= {shift_reg[6:0], sda_s};
                    cnt_reg   <= cnt_reg + 4'h1;
                end
                ST_RDATA_ACK: begin
                    mack_reg <= ~sda_s;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_reg)
                ST_ADDR: begin
                    if (byte_done && shift_reg[7:1] == own_addr) begin
                        rw_reg    <= shift_reg[0];
                        oe_reg    <= 1'b1;
                        state_reg <= ST_ADDR_ACK;
                    end else if (byte_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    cnt_reg <= 4'h0;
                    if (rw_reg) begin
                        shift_reg <= reg_rdata;
                        oe_reg    <= ~reg_rdata[7];
                        state_reg <= ST_RDATA;
                    end else begin
                        oe_reg    <= 1'b0;
                        state_reg <= ST_REG;
                    end
                end
                ST_REG: begin
                    if (byte_done) begin
                        ptr_reg   <= shift_reg[OFS_W-1:0];
                        oe_reg    <= 1'b1;
                        state_reg <= ST_REG_ACK;
                    end
                end
                ST_WDATA: begin
                    if (byte_done) begin
                        ptr_reg   <= ptr_reg + 7'h01;
                        oe_reg    <= 1'b1;
                        state_reg <= ST_WDATA_ACK;
                    end
                end
                ST_REG_ACK, ST_WDATA_ACK: begin
                    oe_reg    <= 1'b0;
                    cnt_reg   <= 4'h0;
                    state_reg <= ST_WDATA;
                end
                ST_RDATA: begin
                    if (cnt_reg == LAST_BIT_IDX) begin
                        oe_reg    <= 1'b0;
                        ptr_reg   <= ptr_reg + 7'h01;
                        state_reg <= ST_RDATA_ACK;
                    end else begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        oe_reg    <= ~shift_reg[6];
                        cnt_reg   <= cnt_reg + 4'h1;
                    end
                end
                ST_RDATA_ACK: begin
                    cnt_reg <= 4'h0;
                    if (mack_reg) begin
                        shift_reg <= reg_rdata;
                        oe_reg    <= ~reg_rdata[7];
                        state_reg <= ST_RDATA;
                    end else begin
                        // Not-acknowledge: release and wait for stop
                        oe_reg    <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Open drain: the pad only ever pulls low
    assign O_SDA_OUT      = 1'b0;
    assign O_SDA_OE       = oe_reg;
    assign O_PAGE         = page_reg;
    assign O_BROADCAST_EN = bcast_reg;

endmodule

`default_nettype wire

// ---- verif/i2c_paged_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Port checker for the paged register target
// ------------------------------------------------------------------
module i2c_paged_checker
    import i2c_paged_pkg::*;
(
    input  wire logic       I_CLK,
    input  wire logic       I_RST,
    input  wire logic       I_SCL,
    input  wire logic       I_SDA,
    input  wire logic       O_SDA_OUT,
    input  wire logic       O_SDA_OE,
    input  wire logic [7:0] O_PAGE,
    input  wire logic       O_BROADCAST_EN
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    sequence start_seq;
        I_SCL && $past(I_SCL) && $fell(I_SDA);
    endsequence
    sequence drive_seq;
        $rose(O_SDA_OE) && !I_SCL;
    endsequence
    // Reset must be watched while it is high, so it overrides the default disable
    a_reset_idle: assert property (disable iff (1'b0)
        I_RST |=> O_PAGE == 8'h00 && !O_SDA_OE && !O_BROADCAST_EN)
        else $error("reset state wrong");
    a_out_zero: assert property (
        O_SDA_OUT == 1'b0)
        else $error("sda drive value not low");
    a_page_low: assert property (
        $changed(O_PAGE) |-> !$past(I_SCL, 2))
        else $error("page moved outside clock low");
    a_bcast_low: assert property (
        $changed(O_BROADCAST_EN) |-> !$past(I_SCL, 2))
        else $error("broadcast enable moved outside clock low");
    a_oe_scl_low: assert property (
        $changed(O_SDA_OE) |-> !I_SCL)
        else $error("sda drive changed while clock high");
    a_oe_hold: assert property (
        drive_seq |-> O_SDA_OE [*7])
        else $error("sda drive shorter than a bit");
    a_oe_release: assert property (
        $rose(O_SDA_OE) |-> ##[1:80] $fell(O_SDA_OE))
        else $error("sda drive not released");
    a_start_quiet: assert property (
        start_seq |=> !O_SDA_OE [*8])
        else $error("sda driven right after start");
endmodule
`default_nettype wire

// ---- verif/i2c_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Bus controller model, open drain on SDA
// ------------------------------------------------------------------
module i2c_host_model (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output var  logic o_scl,
    output var  logic o_sda_low
);
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // SDA moves only mid low phase, so the target never sees a false start
    task automatic bit_io(input logic b, output logic r);
        o_sda_low = !b;
        tick(2);
        o_scl = 1'b1;
        tick(2);
        r = i_sda;
        tick(2);
        o_scl = 1'b0;
        tick(2);
    endtask
    // Start or stop; the clock stands high after a stop
    task automatic cond(input logic is_start);
        o_sda_low = !is_start;
        tick(2);
        o_scl = 1'b1;
        tick(4);
        o_sda_low = is_start;
        tick(4);
        o_scl = !is_start;
        tick(2);
    endtask
    task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
                         output logic r);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(last, r);
    endtask
endmodule
`default_nettype wire

// ---- verif/i2c_paged_target_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Bench with an array based register model fed from a queue of write bytes
// ------------------------------------------------------------------
module i2c_paged_target_tb_top
    import i2c_paged_pkg::*;
();
    logic       clk;
    logic       i_rst;
    logic       scl;
    logic       sda_low;
    logic       sda_oe;
    logic       sda_out;
    logic [7:0] page_out;
    logic       bcast_out;
    wire        sda;
    int         fails;
    int         n_compared;
    int         seed;
    int         page;
    logic       bcast;
    logic [6:0] addr;
    logic [7:0] wq[$];
    logic [7:0] mem [0:4][0:127];
    // Pull-up: the line is high unless someone pulls it low
    assign sda = !(sda_low || (sda_oe && !sda_out));
    i2c_paged_target i2c_paged_target_inst (.I_CLK(clk), .I_RST(i_rst), .I_SCL(scl), .I_SDA(sda),
        .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .O_PAGE(page_out), .O_BROADCAST_EN(bcast_out));
    i2c_host_model i2c_host_model_inst (.i_clk(clk), .i_sda(sda), .o_scl(scl),
        .o_sda_low(sda_low));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] expv);
        n_compared++;
        if (seen !== expv) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, expv, seen);
        end
    endtask
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic ack_exp);
        logic [7:0] q;
        logic       k;
        int         o;
        i2c_host_model_inst.cond(1'b1);
        i2c_host_model_inst.xbyte({a, 1'b0}, 1'b1, q, k);
        chk("addr_ack", {7'h00, !k}, {7'h00, ack_exp});
        if (!k) begin
            i2c_host_model_inst.xbyte(r, 1'b1, q, k);
            chk("reg_ack", {7'h00, k}, 8'h00);
            foreach (wq[i]) begin
                i2c_host_model_inst.xbyte(wq[i], 1'b1, q, k);
                chk("data_ack", {7'h00, k}, 8'h00);
                o = (int'(r[6:0]) + i) % PAGE_LOCS;
                // The self-clearing reset at offset 1 of page 0 is never stored
                if (o == 0) page = int'(wq[i]);
                else if (page != 0 || o != 1) mem[page][o] = wq[i];
                if (page == 0 && o == 2) bcast = wq[i][BCAST_EN_BIT];
            end
        end
        i2c_host_model_inst.cond(1'b0);
    endtask
    task automatic rd(input logic [7:0] r, input int n);
        logic [7:0] d;
        logic [7:0] e;
        logic       k;
        int         o;
        i2c_host_model_inst.cond(1'b1);
        i2c_host_model_inst.xbyte({addr, 1'b0}, 1'b1, d, k);
        i2c_host_model_inst.xbyte(r, 1'b1, d, k);
        i2c_host_model_inst.cond(1'b1);
        i2c_host_model_inst.xbyte({addr, 1'b1}, 1'b1, d, k);
        chk("rd_addr_ack", {7'h00, k}, 8'h00);
        for (int i = 0; i < n; i++) begin
            o = (int'(r[6:0]) + i) % PAGE_LOCS;
            i2c_host_model_inst.xbyte(8'hff, i == n - 1, d, k);
            e = (o == 0) ? 8'(page) : (page == 0 && o == 1) ? 8'h00 : mem[page][o];
            chk("rd_data", d, e);
        end
        i2c_host_model_inst.cond(1'b0);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        final_report();
    end
    initial begin
        i_rst = 1'b1;
        seed = 59251;
        page = 0;
        bcast = 1'b0;
        addr = TARGET_ADDR;
        repeat (16) @(posedge clk);
        #1 i_rst = 1'b0;
        i2c_host_model_inst.tick(4);
        chk("page", page_out, 8'(page));
        chk("bcast", {7'h00, bcast_out}, {7'h00, bcast});
        repeat (4) wq.push_back(8'($random(seed)));
        wr(TARGET_ADDR, 8'h03, 1'b1);
        rd(8'h03, 4);
        rd(8'h85, 1);
        // Only the stored pages are visited
        for (int pg = 2; pg <= 4; pg++) begin
            wq = {8'(pg)};
            wr(TARGET_ADDR, 8'h00, 1'b1);
            chk("page", page_out, 8'(pg));
            wq = {8'($random(seed)), 8'($random(seed))};
            wr(TARGET_ADDR, 8'h7e, 1'b1);
            rd(8'h7e, 3);
        end
        wq = {8'h00, 8'h01};
        wr(TARGET_ADDR, 8'h00, 1'b1);
        chk("page", page_out, 8'(page));
        rd(8'h00, 2);
        wr(7'h4d, 8'h00, 1'b0);
        wq = {8'h04};
        wr(TARGET_ADDR, 8'h02, 1'b1);
        chk("bcast", {7'h00, bcast_out}, {7'h00, bcast});
        wr(TARGET_ADDR, 8'h02, 1'b0);
        addr = BCAST_ADDR;
        rd(8'h02, 1);
        wq = {8'h00};
        wr(BCAST_ADDR, 8'h02, 1'b1);
        chk("bcast", {7'h00, bcast_out}, {7'h00, bcast});
        addr = TARGET_ADDR;
        wq = {8'h03};
        wr(TARGET_ADDR, 8'h00, 1'b1);
        i_rst = 1'b1;
        i2c_host_model_inst.tick(3);
        i_rst = 1'b0;
        page = 0;
        bcast = 1'b0;
        i2c_host_model_inst.tick(4);
        chk("page", page_out, 8'(page));
        chk("bcast", {7'h00, bcast_out}, {7'h00, bcast});
        final_report();
    end
endmodule
bind i2c_paged_target i2c_paged_checker i2c_paged_checker_inst (.I_CLK(I_CLK), .I_RST(I_RST),
    .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE), .O_PAGE(O_PAGE),
    .O_BROADCAST_EN(O_BROADCAST_EN));
`default_nettype wire
